// *** verilog/asct_top.sv ***
// asynchronous serial transmitter and receiver with mute, wishbone slave
//
// Contract
// R1 - status read then data write clears txe, tc
// R2 - write while sending goes to holding buffer
// R3 - write while idle loads shifter, txe set
// R4 - txe set when holding empties; interrupt if enabled
// R5 - tc set after stop bit; interrupt if enabled
// R6 - break frames while set, then one high bit
// R7 - enabling transmitter sends one idle frame first
// R8 - 8 or 9 bit words, ninth bit stored
// R9 - receive lsb first into holding buffer
// R10 - receiver enable starts start bit search
// R11 - completed word sets rx full, interrupt
// R12 - status read then data read clears full
// R13 - overrun flag, buffered word kept, interrupt
// R14 - samples 8,9,10 must agree else noise
// R15 - noise flag rises with full, no interrupt
// R16 - false start discarded, noise held for later
// R17 - missing stop or break sets framing flag
// R18 - idle frame acts as character, idle interrupt
// R19 - rate is clock/16/coarse/power of two
// R20 - nonzero fine divider divides further, zero bypasses
// R21 - mute blocks rx flags and rx interrupts
// R22 - idle or address mark wakes from mute
// R23 - line low start, high stop and idle
// R24 - ninth transmit bit from its own field
// R25 - sixteen samples, majority of 8,9,10
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "asct_defs.svh"
module asct_top import asct_pkg::*; (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // interrupt
  input wire logic IRQ_MASK_IN,
  output logic IRQ_OUT,
  // serial line
  input wire logic SERIAL_IN,
  output logic TX_OUT
);
  asct_ctl_type ctl;
  asct_baud_type baud_select;
  logic [7:0] tx_fine_divider, rx_fine_divider, wdat, rd_val, tx_holding, rx_holding;
  logic m_sel, wake_sel, tx_ninth_bit, rx_ninth_bit, ack, seen;
  logic wb_req, wb_wr, wb_rd, st_rd, d_rd, d_wr;
  logic tx_buffer_empty_flag, tx_done_flag, rx_full_flag, idle_flag, ovr_flag, noise_flag, framing_flag;

  assign wb_req = WB_CYC_IN && WB_STB_IN && !ack;
  assign wb_wr = wb_req && WB_WE_IN && WB_SEL_IN[0];
  assign wb_rd = wb_req && !WB_WE_IN;
  assign wdat = WB_DAT_IN[7:0];
  assign st_rd = wb_rd && WB_ADR_IN == `ASCT_STATUS_OFS;
  assign d_rd = wb_rd && WB_ADR_IN == `ASCT_DATA_OFS;
  assign d_wr = wb_wr && WB_ADR_IN == `ASCT_DATA_OFS;
  assign WB_ACK_OUT = ack;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ack <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end else begin
      ack <= wb_req;
      if (wb_rd) begin
        WB_DAT_OUT <= {24'h0, rd_val};
      end
    end
  end

  always_comb begin
    unique case (WB_ADR_IN)
      `ASCT_STATUS_OFS: rd_val = {tx_buffer_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
                                  ovr_flag, noise_flag, framing_flag, 1'b0};
      `ASCT_DATA_OFS: rd_val = rx_holding;
      `ASCT_CTL1_OFS: rd_val = {rx_ninth_bit, tx_ninth_bit, 1'b0, m_sel, wake_sel, 3'h0};
      `ASCT_CTL2_OFS: rd_val = ctl;
      `ASCT_BAUD_OFS: rd_val = baud_select;
      `ASCT_RXFINE_OFS: rd_val = rx_fine_divider;
      `ASCT_TXFINE_OFS: rd_val = tx_fine_divider;
      default: rd_val = 8'h00;
    endcase
  end

  // the read-then-access sequence: armed by a status read, spent by any data access
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      seen <= 1'b0;
    end else if (st_rd) begin
      seen <= 1'b1;
    end else if (d_rd || d_wr) begin
      seen <= 1'b0;
    end
  end

  // rate dividers
  function automatic logic [18:0] div_of(input logic [1:0] pr, input logic [2:0] r, input logic [7:0] e);
    logic [4:0] p;
    logic [18:0] d;
    unique case (pr)
      2'h0: p = `ASCT_PR0;
      2'h1: p = `ASCT_PR1;
      2'h2: p = `ASCT_PR2;
      2'h3: p = `ASCT_PR3;
    endcase
    d = 19'(p) << r; // [R19]
    if (e != 8'h00) begin
      d = 19'(d * e); // [R20]
    end
    return d;
  endfunction : div_of

  logic [18:0] tx_cnt, rx_cnt, tx_div, rx_div;
  logic tx_tick, rx_tick, tx_busy;
  assign tx_div = div_of(baud_select.coarse_divider, baud_select.tx_rate_divider, tx_fine_divider);
  assign rx_div = div_of(baud_select.coarse_divider, baud_select.rx_rate_divider, rx_fine_divider);
  assign tx_tick = tx_cnt == tx_div - 19'h1;
  assign rx_tick = ctl.rx_enable && rx_cnt == rx_div - 19'h1;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_cnt <= 19'h0;
      rx_cnt <= 19'h0;
    end else begin
      tx_cnt <= (tx_tick || !(ctl.tx_enable || tx_busy)) ? 19'h0 : tx_cnt + 19'h1;
      rx_cnt <= (rx_tick || !ctl.rx_enable) ? 19'h0 : rx_cnt + 19'h1;
    end
  end

  // transmitter
  logic [10:0] tx_shift, tx_frame;
  logic [7:0] tx_word;
  logic [3:0] tx_left, tx_sub, frame_len;
  logic hold_full, post_one, idle_pend, te_d, bit_end, tx_end, tx_free;
  logic go_brk, go_one, go_idle, go_hold, go_direct;
  assign frame_len = m_sel ? `ASCT_LEN9 : `ASCT_LEN8;
  assign bit_end = tx_busy && tx_tick && tx_sub == `ASCT_SUB_LAST;
  assign tx_end = bit_end && tx_left == 4'h1;
  assign tx_free = ctl.tx_enable && (!tx_busy || tx_end);
  assign go_brk = tx_free && ctl.send_break_ctl; // [R6]
  assign go_one = tx_free && !ctl.send_break_ctl && post_one;
  assign go_idle = tx_free && !ctl.send_break_ctl && !post_one && idle_pend; // [R7]
  assign go_hold = tx_free && !ctl.send_break_ctl && !post_one && !idle_pend && hold_full; // [R2]
  assign go_direct = tx_free && !tx_busy && !ctl.send_break_ctl && !post_one && !idle_pend &&
                     !hold_full && d_wr; // [R3]
  assign tx_word = go_hold ? tx_holding : wdat;
  // stop high, start low, lsb first; 8-bit frames simply end before bit 10
  assign tx_frame = {1'b1, m_sel ? tx_ninth_bit : 1'b1, tx_word, 1'b0}; // [R24] [R23]
  assign TX_OUT = tx_shift[0];

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_shift <= 11'h7ff;
      tx_left <= 4'h0;
      tx_sub <= 4'h0;
      tx_busy <= 1'b0;
    end else if (go_brk || go_one || go_idle || go_hold || go_direct) begin
      tx_busy <= 1'b1;
      tx_sub <= 4'h0;
      tx_left <= go_one ? 4'h1 : frame_len;
      tx_shift <= go_brk ? 11'h000 : (go_one || go_idle) ? 11'h7ff : tx_frame; // [R6]
    end else if (bit_end) begin
      // park the line high after the last bit, even after an 8-bit break frame
      tx_shift <= (tx_left == 4'h1) ? 11'h7ff : {1'b1, tx_shift[10:1]}; // [R23]
      tx_left <= tx_left - 4'h1;
      tx_sub <= 4'h0;
      tx_busy <= tx_left != 4'h1;
    end else if (tx_busy && tx_tick) begin
      tx_sub <= tx_sub + 4'h1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      post_one <= 1'b0;
      idle_pend <= 1'b0;
      te_d <= 1'b0;
    end else begin
      te_d <= ctl.tx_enable;
      if (go_brk) begin
        post_one <= 1'b1;
      end else if (go_one) begin
        post_one <= 1'b0;
      end
      if (ctl.tx_enable && !te_d) begin
        idle_pend <= 1'b1; // [R7]
      end else if (go_idle) begin
        idle_pend <= 1'b0;
      end
    end
  end

  // dropping the enable discards the held word
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hold_full <= 1'b0;
      tx_holding <= 8'h00;
    end else if (!ctl.tx_enable) begin
      hold_full <= 1'b0;
    end else if (d_wr && !go_direct) begin
      hold_full <= 1'b1; // [R2]
      tx_holding <= wdat;
    end else if (go_hold) begin
      hold_full <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      if (go_hold || go_direct || !ctl.tx_enable) begin
        tx_buffer_empty_flag <= 1'b1; // [R3] [R4]
      end else if (seen && d_wr) begin
        tx_buffer_empty_flag <= 1'b0; // [R1]
      end
      if (tx_end) begin
        tx_done_flag <= 1'b1; // [R5]
      end else if (seen && d_wr) begin
        tx_done_flag <= 1'b0; // [R1]
      end
    end
  end

  // receiver
  asct_rx_state_type rx_state;
  logic [8:0] rx_sh;
  logic [7:0] idle_cnt;
  logic [3:0] scnt, k, bit_idx, stop_idx;
  logic [2:0] hist;
  logic v8, v9, maj, dis, edge_bad, noise_acc, nf_pend, idle_armed, re_d;
  logic eval, rx_done, idle_evt, wake_addr, accept;
  assign k = scnt + 4'h1;
  assign stop_idx = m_sel ? 4'ha : 4'h9; // [R8]
  assign maj = (v8 & v9) | (v8 & SERIAL_IN) | (v9 & SERIAL_IN); // [R25]
  assign dis = !(v8 == v9 && v9 == SERIAL_IN); // [R14]
  assign eval = rx_tick && rx_state == RX_RECV && k == `ASCT_SMP_C;
  assign rx_done = eval && bit_idx == stop_idx;
  assign idle_evt = rx_tick && rx_state == RX_HUNT && idle_armed && SERIAL_IN &&
                    idle_cnt == {frame_len, 4'h0} - 8'h1;
  assign wake_addr = ctl.mute_ctl && wake_sel && rx_sh[8]; // [R22]
  assign accept = rx_done && (!ctl.mute_ctl || wake_addr); // [R21]

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_state <= RX_HUNT;
      hist <= 3'h0;
      scnt <= 4'h0;
      bit_idx <= 4'h0;
      v8 <= 1'b0;
      v9 <= 1'b0;
      edge_bad <= 1'b0;
      noise_acc <= 1'b0;
      rx_sh <= 9'h000;
    end else if (!ctl.rx_enable) begin
      rx_state <= RX_HUNT; // [R10]
      hist <= 3'h0;
    end else if (rx_tick) begin
      unique case (rx_state)
        RX_HUNT: begin
          hist <= {hist[1:0], SERIAL_IN};
          if (!SERIAL_IN && hist == 3'h7) begin
            rx_state <= RX_RECV; // [R10]
            scnt <= 4'h1;
            bit_idx <= 4'h0;
            edge_bad <= 1'b0;
            noise_acc <= 1'b0;
          end
        end
        RX_RECV: begin
          scnt <= k;
          if (k == `ASCT_SMP_A) v8 <= SERIAL_IN;
          if (k == `ASCT_SMP_B) v9 <= SERIAL_IN;
          if (bit_idx == 4'h0 && SERIAL_IN &&
              (k == `ASCT_EDGE_A || k == `ASCT_EDGE_B || k == `ASCT_EDGE_C)) begin
            edge_bad <= 1'b1;
          end
          if (eval) begin
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == 4'h0) begin
              noise_acc <= edge_bad;
              if (v8 || v9 || SERIAL_IN) begin
                rx_state <= RX_HUNT; // [R16]
                hist <= 3'h0;
              end
            end else if (bit_idx == stop_idx) begin
              rx_state <= RX_HUNT;
              hist <= {3{maj}};
            end else begin
              rx_sh <= {maj, rx_sh[8:1]}; // [R9]
              noise_acc <= noise_acc | dis; // [R14]
            end
          end
        end
      endcase
    end
  end

  // idle detection re-arms after each frame and on enable
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      idle_cnt <= 8'h0;
      idle_armed <= 1'b0;
      re_d <= 1'b0;
    end else begin
      re_d <= ctl.rx_enable;
      if (rx_tick) begin
        idle_cnt <= (rx_state == RX_HUNT && SERIAL_IN) ? idle_cnt + 8'h1 : 8'h0;
      end
      if ((ctl.rx_enable && !re_d) || rx_done) begin
        idle_armed <= 1'b1;
      end else if (idle_evt) begin
        idle_armed <= 1'b0;
      end
    end
  end

  // receive flags; hardware set wins over the software clear sequence
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_full_flag <= 1'b0;
      ovr_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_flag <= 1'b0;
      idle_flag <= 1'b0;
      nf_pend <= 1'b0;
      rx_holding <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else begin
      if (seen && d_rd) begin
        rx_full_flag <= 1'b0; // [R12]
        ovr_flag <= 1'b0; // [R13]
        noise_flag <= 1'b0; // [R15]
        framing_flag <= 1'b0; // [R17]
        idle_flag <= 1'b0;
      end
      if (eval && bit_idx == 4'h0 && (v8 || v9 || SERIAL_IN)) begin
        nf_pend <= 1'b1; // [R16]
      end
      if (accept && rx_full_flag && !(seen && d_rd)) begin
        ovr_flag <= 1'b1; // [R13]
      end else if (accept) begin
        rx_full_flag <= 1'b1; // [R11]
        rx_holding <= m_sel ? rx_sh[7:0] : rx_sh[8:1]; // [R9]
        rx_ninth_bit <= rx_sh[8]; // [R8]
        noise_flag <= noise_acc | dis | nf_pend; // [R15]
        framing_flag <= !maj; // [R17]
        nf_pend <= 1'b0;
      end
      if (idle_evt && !ctl.mute_ctl) begin
        idle_flag <= 1'b1; // [R18]
      end
    end
  end

  // software control registers; a mute write wins over a hardware wake
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctl <= `ASCT_CTL_RST;
      baud_select <= `ASCT_BAUD_RST;
      tx_fine_divider <= `ASCT_FINE_RST;
      rx_fine_divider <= `ASCT_FINE_RST;
      m_sel <= 1'b0;
      wake_sel <= 1'b0;
      tx_ninth_bit <= 1'b0;
    end else begin
      if ((idle_evt && ctl.mute_ctl && !wake_sel) || (rx_done && wake_addr)) begin
        ctl.mute_ctl <= 1'b0; // [R22]
      end
      if (wb_wr) begin
        unique case (WB_ADR_IN)
          `ASCT_CTL1_OFS: begin
            m_sel <= wdat[`ASCT_CTL1_M_BIT];
            wake_sel <= wdat[`ASCT_CTL1_WAKE_BIT];
            tx_ninth_bit <= wdat[`ASCT_CTL1_T9_BIT];
          end
          `ASCT_CTL2_OFS: ctl <= wdat;
          `ASCT_BAUD_OFS: baud_select <= wdat;
          `ASCT_RXFINE_OFS: rx_fine_divider <= wdat;
          `ASCT_TXFINE_OFS: tx_fine_divider <= wdat;
          default: ;
        endcase
      end
    end
  end

  // global mask comes from the cpu; mute also hides receive sources
  assign IRQ_OUT = !IRQ_MASK_IN && ((tx_buffer_empty_flag && ctl.tx_empty_irq_en) || // [R4]
                   (tx_done_flag && ctl.tx_done_irq_en) || // [R5]
                   (!ctl.mute_ctl && (((rx_full_flag || ovr_flag) && ctl.rx_full_irq_en) || // [R11] [R13] [R21]
                   (idle_flag && ctl.line_quiet_irq_en)))); // [R18]

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_status_read;
    st_rd;
  endsequence
  sequence s_data_write;
    d_wr && !go_direct && !go_hold && !tx_end && ctl.tx_enable;
  endsequence
  property p_armed;
    s_status_read |=> seen;
  endproperty
  a_armed: assert property (p_armed) else $error("clear sequence not armed"); // [R1]
  property p_tx_clear;
    seen ##0 s_data_write |=> !tx_buffer_empty_flag && !tx_done_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("txe/tc not cleared"); // [R1]
  property p_hold;
    d_wr && tx_busy && !tx_end && ctl.tx_enable |=> hold_full && tx_holding == $past(wdat);
  endproperty
  a_hold: assert property (p_hold) else $error("busy write not held"); // [R2]
  property p_direct;
    go_direct |=> tx_busy && tx_buffer_empty_flag && !TX_OUT;
  endproperty
  a_direct: assert property (p_direct) else $error("direct load failed"); // [R3]
  property p_done;
    tx_end |=> tx_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("tc not set"); // [R5]
  property p_brk;
    go_brk |=> !TX_OUT [*2];
  endproperty
  a_brk: assert property (p_brk) else $error("break not low"); // [R6]
  property p_idle_first;
    $rose(ctl.tx_enable) && !tx_busy |=> ##[0:2] idle_pend;
  endproperty
  a_idle_first: assert property (p_idle_first) else $error("no idle frame pending"); // [R7]
  property p_line_high;
    !tx_busy |-> TX_OUT;
  endproperty
  a_line_high: assert property (p_line_high) else $error("line not high"); // [R23]
  property p_full;
    accept && !rx_full_flag |=> rx_full_flag && framing_flag == !$past(maj);
  endproperty
  a_full: assert property (p_full) else $error("full not set"); // [R11]
  property p_ovr;
    accept && rx_full_flag && !(seen && d_rd) |=> ovr_flag && $stable(rx_holding);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun wrong"); // [R13]
  property p_mute;
    ctl.mute_ctl && !rx_done |=> !$rose(rx_full_flag) && !$rose(idle_flag);
  endproperty
  a_mute: assert property (p_mute) else $error("flag set while muted"); // [R21]
endmodule : asct_top
`default_nettype wire

// *** verilog/asct_defs.svh ***
// register map, field positions, reset values and sampling constants for the serial unit
`ifndef ASCT_DEFS_SVH
`define ASCT_DEFS_SVH
`define ASCT_STATUS_OFS 8'h00
`define ASCT_DATA_OFS 8'h04
`define ASCT_CTL1_OFS 8'h08
`define ASCT_CTL2_OFS 8'h0c
`define ASCT_BAUD_OFS 8'h10
`define ASCT_RXFINE_OFS 8'h14
`define ASCT_TXFINE_OFS 8'h18
`define ASCT_CTL1_M_BIT 4
`define ASCT_CTL1_WAKE_BIT 3
`define ASCT_CTL1_T9_BIT 6
`define ASCT_CTL_RST 8'h00
`define ASCT_BAUD_RST 8'h00
`define ASCT_FINE_RST 8'h00
`define ASCT_PR0 5'h01
`define ASCT_PR1 5'h03
`define ASCT_PR2 5'h04
`define ASCT_PR3 5'h0d
`define ASCT_LEN8 4'ha
`define ASCT_LEN9 4'hb
`define ASCT_SMP_A 4'h8
`define ASCT_SMP_B 4'h9
`define ASCT_SMP_C 4'ha
`define ASCT_EDGE_A 4'h3
`define ASCT_EDGE_B 4'h5
`define ASCT_EDGE_C 4'h7
`define ASCT_SUB_LAST 4'hf
`endif

// *** verilog/asct_pkg.sv ***
// types shared by the serial unit
package asct_pkg;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_full_irq_en;
    logic line_quiet_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic mute_ctl;
    logic send_break_ctl;
  } asct_ctl_type;
  typedef struct packed {
    logic [1:0] coarse_divider;
    logic [2:0] tx_rate_divider;
    logic [2:0] rx_rate_divider;
  } asct_baud_type;
  typedef enum logic {RX_HUNT, RX_RECV} asct_rx_state_type;
endpackage : asct_pkg

// *** sim/asct_line_model.sv ***
// far-end serial transceiver: drives frames onto the line and decodes what arrives
`timescale 1ns/1ps
`default_nettype none
module asct_line_model (
  // clock
  input wire logic clk_in,
  // serial line
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 16;
  int nbits = 8;
  logic [9:0] got[$];
  initial line_out = 1'b1; // mark level between frames
  // glitch names a bit (0 is start); one clock near its 9th sample is inverted
  task automatic send(input logic [8:0] d, input int n, input logic stop, input int glitch);
    logic [10:0] f;
    f = 11'h7ff;
    f[0] = 1'b0; // start low, data lsb first, stop bit at the level given by stop
    for (int i = 0; i < n; i++) f[i + 1] = d[i];
    f[n + 1] = stop;
    for (int b = 0; b < n + 2; b++) begin
      for (int c = 0; c < bit_clks; c++) begin
        @(posedge clk_in);
        line_out <= (b == glitch && c == bit_clks / 2) ? ~f[b] : f[b];
      end
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask : send
  // mid-bit sampling; a run of break frames yields one entry since no edge separates them
  always begin
    logic [9:0] r;
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    if (line_in === 1'b0) begin
      r = 10'h000;
      for (int i = 0; i <= nbits; i++) begin
        repeat (bit_clks) @(posedge clk_in);
        r[i] = line_in;
      end
      got.push_back(r);
    end
  end
endmodule : asct_line_model
`default_nettype wire

// *** sim/test_async_serial_txrx_with_mute.sv ***
// bench for the serial unit: bus tasks, far-end model, flag, data and line checks
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_txrx_with_mute;
  logic clk, rst_b, cyc, stb, we, ack, irq_mask, irq, rx_line, tx_line;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int errors = 0;
  int samples_checked = 0;
  asct_top asct_top_i (
    .CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_MASK_IN(irq_mask),
    .IRQ_OUT(irq), .SERIAL_IN(rx_line), .TX_OUT(tx_line));
  asct_line_model asct_line_model_i (.clk_in(clk), .line_in(tx_line), .line_out(rx_line));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request stands until the rising edge that samples ack high; data taken and request dropped there
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, {2'b00, exp}, {2'b00, q & m});
  endtask : rd_chk
  task automatic flush;
    logic [7:0] q;
    wb(1'b0, 8'h00, 8'h00, q);
    wb(1'b0, 8'h04, 8'h00, q);
  endtask : flush
  task automatic got_chk(input logic [9:0] exp);
    int n;
    n = 0;
    while (asct_line_model_i.got.size() == 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (asct_line_model_i.got.size() == 0) begin
      errors++;
      $display("mismatch line frame expected %h seen none", exp);
    end else begin
      chk("line frame", exp, asct_line_model_i.got.pop_front());
    end
  endtask : got_chk
  // far-end frame, then flags beside full, the word, and flags gone after the read pair
  task automatic rx_one(input logic [8:0] d, input int n, input logic stop, input int g, input logic [7:0] fl);
    asct_line_model_i.send(d, n, stop, g);
    repeat (2 * asct_line_model_i.bit_clks) @(posedge clk);
    rd_chk("rx flags", 8'h00, 8'h2e, fl);
    rd_chk("rx data", 8'h04, 8'hff, d[7:0]);
    rd_chk("rx flags cleared", 8'h00, 8'h2e, 8'h00);
  endtask : rx_one
  function automatic int bit_len(input logic [1:0] pr, input logic [2:0] r, input logic [7:0] fine);
    int c[4] = '{1, 3, 4, 13};
    return 16 * c[pr] * (1 << r) * (fine == 8'h00 ? 1 : int'(fine));
  endfunction : bit_len
  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask : done_test
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    int n;
    logic [7:0] b0, b1, b2, r;
    {cyc, stb, we, irq_mask, rst_b} = 5'h00;
    adr = 8'h00;
    sel = 4'h1;
    wdat = 32'h00000000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    void'($urandom(32'hf15adfd5));
    rd_chk("status reset", 8'h00, 8'hff, 8'hc0);
    rd_chk("ctl1 reset", 8'h08, 8'hff, 8'h00);
    wr(8'h1c, 8'h5a);
    rd_chk("unmapped", 8'h1c, 8'hff, 8'h00);
    done_test("reset");
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    wr(8'h0c, 8'h0c);
    fork
      begin
        n = 0;
        while (tx_line !== 1'b0 && n < 400) begin
          @(negedge clk);
          n++;
        end
      end
      begin
        rd_chk("status", 8'h00, 8'h00, 8'h00);
        wr(8'h04, b0);
      end
    join
    chk("idle frame span", 10'h001, 10'(n >= 150 && n <= 170));
    got_chk({2'b01, b0});
    repeat (16) @(posedge clk);
    rd_chk("status after frame", 8'h00, 8'hc0, 8'hc0);
    wr(8'h04, b1);
    @(negedge clk);
    chk("start at once", 10'h000, {9'h000, tx_line});
    rd_chk("empty after load", 8'h00, 8'hc0, 8'h80);
    wr(8'h04, b2);
    rd_chk("word held", 8'h00, 8'hc0, 8'h00);
    wr(8'h0c, 8'h8c);
    @(negedge clk);
    chk("irq quiet", 10'h000, {9'h000, irq});
    got_chk({2'b01, b1});
    got_chk({2'b01, b2});
    @(negedge clk);
    chk("irq empty", 10'h001, {9'h000, irq});
    @(posedge clk);
    irq_mask <= 1'b1;
    @(negedge clk);
    chk("irq masked", 10'h000, {9'h000, irq});
    @(posedge clk);
    irq_mask <= 1'b0;
    wr(8'h0c, 8'h4c);
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("irq done", 10'h001, {9'h000, irq});
    rd_chk("status", 8'h00, 8'h00, 8'h00);
    wr(8'h04, b0);
    @(negedge clk);
    chk("irq done cleared", 10'h000, {9'h000, irq});
    got_chk({2'b01, b0});
    wr(8'h0c, 8'h0d);
    got_chk(10'h000);
    wr(8'h0c, 8'h0c);
    repeat (200) @(posedge clk);
    chk("line high after break", 10'h001, {9'h000, tx_line});
    done_test("transmit");
    flush();
    rx_one({1'b0, 8'($urandom)}, 8, 1'b1, -1, 8'h20);
    rx_one({1'b0, 8'($urandom)}, 8, 1'b1, 3, 8'h24);
    rx_one({1'b0, 8'($urandom)}, 8, 1'b0, -1, 8'h22);
    asct_line_model_i.send(9'h000, 8, 1'b1, 0);
    rx_one({1'b0, 8'($urandom)}, 8, 1'b1, -1, 8'h24);
    wr(8'h0c, 8'h2c);
    flush();
    asct_line_model_i.send({1'b0, b1}, 8, 1'b1, -1);
    asct_line_model_i.send({1'b0, b2}, 8, 1'b1, -1);
    repeat (32) @(posedge clk);
    chk("irq full", 10'h001, {9'h000, irq});
    rd_chk("overrun", 8'h00, 8'h2e, 8'h28);
    rd_chk("first word kept", 8'h04, 8'hff, b1);
    rd_chk("overrun cleared", 8'h00, 8'h2e, 8'h00);
    done_test("receive");
    wr(8'h08, 8'h08);
    wr(8'h0c, 8'h0e);
    flush();
    asct_line_model_i.send({2'b00, 7'($urandom)}, 8, 1'b1, -1);
    repeat (32) @(posedge clk);
    rd_chk("muted flags", 8'h00, 8'h2e, 8'h00);
    rx_one({2'b01, 7'($urandom)}, 8, 1'b1, -1, 8'h20);
    rd_chk("mute released", 8'h0c, 8'hff, 8'h0c);
    wr(8'h08, 8'h50);
    asct_line_model_i.nbits = 9;
    rd_chk("status", 8'h00, 8'h00, 8'h00);
    wr(8'h04, b2);
    got_chk({2'b11, b2});
    flush();
    rx_one({1'b1, b0}, 9, 1'b1, -1, 8'h20);
    rd_chk("ninth bit", 8'h08, 8'h80, 8'h80);
    wr(8'h08, 8'h00);
    asct_line_model_i.nbits = 8;
    done_test("mute and nine bits");
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'h4a);
    wr(8'h18, 8'h02);
    wr(8'h14, 8'h00);
    // both directions come out equal with these settings
    asct_line_model_i.bit_clks = bit_len(2'b01, 3'b001, 8'h02);
    wr(8'h0c, 8'h0c);
    rd_chk("status", 8'h00, 8'h00, 8'h00);
    wr(8'h04, b1);
    got_chk({2'b01, b1});
    flush();
    rx_one({1'b0, b2}, 8, 1'b1, -1, 8'h20);
    done_test("rates");
    give_verdict();
  end
endmodule : test_async_serial_txrx_with_mute
`default_nettype wire
